// File: pkg/apbu_defs.svh
/*
  Constants for the axis position breakpoint unit: register offsets,
  field positions, reset values and value limits.
  Assumes inclusion by bare name from the design and bench files.
*/
`ifndef APBU_DEFS_SVH
`define APBU_DEFS_SVH

// Register word offsets (byte address = offset, 32-bit words)
`define APBU_REG_CTRL      8'h00
`define APBU_REG_CMD       8'h04
`define APBU_REG_STATUS    8'h08
`define APBU_REG_IRQ_STAT  8'h0c
`define APBU_REG_IRQ_MASK  8'h10
`define APBU_REG_IO_OUT    8'h14
`define APBU_REG_IO_DIR    8'h18
`define APBU_REG_SCALE     8'h1c
`define APBU_REG_BRK_BASE  8'h20
`define APBU_REG_OFS_BASE  8'h40
`define APBU_REG_ARMV_BASE 8'h60
`define APBU_REG_ABSP_BASE 8'h80
`define APBU_AXIS_STRIDE   8'h04

// Control register fields
`define APBU_CTRL_SERVO    0
`define APBU_CTRL_CLOSED   1
`define APBU_CTRL_CLMODE   2
`define APBU_CTRL_LINK_LSB 4

// Command register fields
`define APBU_CMD_OP_LSB    0
`define APBU_CMD_OP_W      2
`define APBU_CMD_AXIS_LSB  4
`define APBU_CMD_REL_BIT   8

// Command opcodes
`define APBU_OP_NONE       2'h0
`define APBU_OP_ARM        2'h1
`define APBU_OP_DISARM     2'h2

// Interrupt status layout: match per axis, then function error
`define APBU_IRQ_ERR_BIT   4

// Reset values
`define APBU_CTRL_RST      8'h03
`define APBU_SCALE_RST     32'h0001_0001

// Signed 31-bit value limits
`define APBU_VAL_MIN       (-32'sd1073741824)
`define APBU_VAL_MAX       (32'sd1073741823)

`endif

// File: pkg/apbu_pkg.sv
/*
  Types for the axis position breakpoint unit.
  Assumes apbu_defs.svh supplies the numeric constants.
*/
package apbu_pkg;
  typedef enum logic [1:0] {
    APBU_IDLE,
    APBU_ARMED
  } apbu_state_t;

  typedef logic signed [31:0] apbu_pos_t;
endpackage

// File: core/apbu_core.sv
/*
  Four-axis position breakpoint comparator with per-axis reference offset,
  double-buffered breakpoint values, 8-bit I/O port and interrupt.
  Assumes a host on a simple strobe register port in the clk domain,
  motion positions supplied in device units by the trajectory logic, and
  the scale/offset conversion sequence of the host firmware being limited
  to the integer ratio held in the scale register.
*/
`timescale 1ns/100ps
`include "apbu_defs.svh"

// Contract
// - Per-axis signed breakpoint, range +-2^30, reset zero, host keeps range.
// - Armed axis equal to active breakpoint toggles its output bit while that port bit's direction is set to output.
// - Axis n drives port bit n (stepper) or n+4 (servo).
// - Loaded breakpoint waits in holding buffer until the arm command.
// - Holding value survives a match; re-arm reuses it without reloading.
// - Arm command selects absolute or relative breakpoint interpretation.
// - Absolute uses scale and offset; relative uses scale only.
// - With link enabled, a match pulses that axis's trigger input.
// - Values are encoder counts on servo, motor steps on stepper.
// - Open-loop-only board errors on load; open-loop mode disables matching.
// - Breakpoint output levels readable through the I/O port read.
// - Per-axis signed offset, range +-2^30, reset zero, host keeps range.
// - Offset applies to absolute positions and readback, not relative ones.
// - Anticipation-time breakpoints bypass the reference offset.
// - Offset stored per axis, takes effect at once, no motion stop.
// - Offset load works in both loop modes; errors on open-loop-only board.
// - Stepper offset is in motor steps.
module apbu_core #(
  parameter int AXES = 4
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Register port
  input  wire logic [7:0]           regAddr,
  input  wire logic [31:0]          regWrData,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic      [31:0]          regRdData,
  // Motion positions, raw device units, and anticipation events
  input  wire logic [AXES*32-1:0]   motionPos,
  input  wire logic [AXES-1:0]      anticipHit,
  // I/O port pins
  input  wire logic [7:0]           ioPinIn,
  output logic      [7:0]           ioPinOut,
  output logic      [7:0]           ioPinOe_n,
  // Trigger buffer inputs and interrupt
  output logic      [AXES-1:0]      trigPulse,
  output logic                      irq
);

  initial begin
    if (AXES != 4) begin
      $error("apbu_core serves exactly four axes");
    end
  end

  // Control and shared registers
  logic [7:0]          ctrl;
  logic [31:0]         scale;
  logic [7:0]          ioOut;
  logic [7:0]          ioDir;
  logic [AXES:0]       irqStat;
  logic [AXES:0]       irqMask;
  logic [7:0]          ioSync1;
  logic [7:0]          ioSync2;

  // Per-axis storage
  apbu_pkg::apbu_pos_t brkHold [AXES];
  apbu_pkg::apbu_pos_t refOfs  [AXES];
  apbu_pkg::apbu_pos_t armVal  [AXES];
  apbu_pkg::apbu_state_t armState [AXES];

  // Decoded control bits
  wire servoVar  = ctrl[`APBU_CTRL_SERVO];
  wire closedBrd = ctrl[`APBU_CTRL_CLOSED];
  wire closedRun = servoVar | ctrl[`APBU_CTRL_CLMODE];
  wire [AXES-1:0] linkEn = ctrl[`APBU_CTRL_LINK_LSB +: AXES];

  // Scale: numerator high, denominator low; a single zero half keeps old value
  wire [15:0] scaleNum = scale[31:16];
  wire [15:0] scaleDen = scale[15:0];

  // Command decode
  wire        cmdWr    = regWr && (regAddr == `APBU_REG_CMD);
  wire [1:0]  cmdOp    = regWrData[`APBU_CMD_OP_LSB +: `APBU_CMD_OP_W];
  wire [1:0]  cmdAxis  = regWrData[`APBU_CMD_AXIS_LSB +: 2];
  wire        cmdRel   = regWrData[`APBU_CMD_REL_BIT];
  wire        cmdArm   = cmdWr && (cmdOp == `APBU_OP_ARM);
  wire        cmdDisarm = cmdWr && (cmdOp == `APBU_OP_DISARM);

  // Scale write decode, identical halves collapse to one
  wire [15:0] wrNum = regWrData[31:16];
  wire [15:0] wrDen = regWrData[15:0];
  wire        scaleSame = (wrNum == wrDen);
  wire [15:0] next_num = scaleSame ? 16'h0001 : ((wrNum == 16'h0000) ? scaleNum : wrNum);
  wire [15:0] next_den = scaleSame ? 16'h0001 : ((wrDen == 16'h0000) ? scaleDen : wrDen);

  // Per-axis decode and compare
  logic [AXES-1:0]     brkWrHit;
  logic [AXES-1:0]     ofsWrHit;
  logic [AXES-1:0]     armHit;
  logic [AXES-1:0]     matchHit;
  logic [AXES-1:0]     errHit;
  apbu_pkg::apbu_pos_t next_arm [AXES];
  apbu_pkg::apbu_pos_t posAxis  [AXES];
  apbu_pkg::apbu_pos_t absPos   [AXES];
  logic [7:0]          toggleMask;

  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : gAxis
      wire [7:0] aOff = 8'(g * 4);
      wire signed [47:0] scaledHold;
      wire signed [47:0] divHold;
      assign brkWrHit[g] = regWr && (regAddr == `APBU_REG_BRK_BASE + aOff);
      assign ofsWrHit[g] = regWr && (regAddr == `APBU_REG_OFS_BASE + aOff);
      assign armHit[g]   = cmdArm && (cmdAxis == 2'(g));
      assign posAxis[g]  = motionPos[g*32 +: 32];
      // Readback in user frame: offset removed from absolute position
      assign absPos[g]   = posAxis[g] - refOfs[g];
      // User units to device units by integer ratio
      assign scaledHold  = 48'(brkHold[g]) * $signed({1'b0, scaleDen});
      assign divHold     = scaledHold / $signed({1'b0, scaleNum});
      // Absolute adds the offset, relative adds the present position
      assign next_arm[g] = cmdRel ? apbu_pkg::apbu_pos_t'(divHold[31:0]) + posAxis[g]
                                  : apbu_pkg::apbu_pos_t'(divHold[31:0]) + refOfs[g];
      // Device units are counts (servo) or steps (stepper)
      assign matchHit[g] = (armState[g] == apbu_pkg::APBU_ARMED) && closedRun
                           && (posAxis[g] == armVal[g]);
      assign errHit[g]   = (brkWrHit[g] || ofsWrHit[g]) && !closedBrd;
      // Servo bits 5..8 are indices 4..7
      assign toggleMask[g]        = matchHit[g] && !servoVar;
      assign toggleMask[g + AXES] = matchHit[g] && servoVar;

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          brkHold[g] <= '0;
          refOfs[g]  <= '0;
        end else begin
          if (brkWrHit[g] && closedBrd) begin
            brkHold[g] <= regWrData;
          end
          if (ofsWrHit[g] && closedBrd) begin
            refOfs[g] <= regWrData;
          end
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          armState[g] <= apbu_pkg::APBU_IDLE;
          armVal[g]   <= '0;
        end else if (armHit[g] && closedBrd) begin
          armState[g] <= apbu_pkg::APBU_ARMED;
          armVal[g]   <= next_arm[g];
        end else if (matchHit[g] || (cmdDisarm && cmdAxis == 2'(g))) begin
          armState[g] <= apbu_pkg::APBU_IDLE;
        end
      end
    end
  endgenerate

  // Anticipation events go straight through, untouched by the offset
  wire [AXES-1:0] trigSrc = (matchHit | anticipHit) & linkEn;

  // Register writes
  wire ctrlWr  = regWr && (regAddr == `APBU_REG_CTRL);
  wire scaleWr = regWr && (regAddr == `APBU_REG_SCALE) && closedBrd;
  wire ioOutWr = regWr && (regAddr == `APBU_REG_IO_OUT);
  wire ioDirWr = regWr && (regAddr == `APBU_REG_IO_DIR);
  wire stClr   = regWr && (regAddr == `APBU_REG_IRQ_STAT);
  wire mskWr   = regWr && (regAddr == `APBU_REG_IRQ_MASK);
  wire [AXES:0] irqSet = {|errHit, matchHit};

  // Host port-write may restore the level; a same-cycle match still toggles it
  wire [7:0] ioBase    = ioOutWr ? regWrData[7:0] : ioOut;
  wire [7:0] next_io   = ioBase ^ (toggleMask & ioDir);
  wire [AXES:0] next_st = (irqStat & ~(stClr ? regWrData[AXES:0] : '0)) | irqSet;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl      <= `APBU_CTRL_RST;
      scale     <= `APBU_SCALE_RST;
      ioOut     <= '0;
      ioDir     <= '0;
      irqStat   <= '0;
      irqMask   <= '0;
      trigPulse <= '0;
      irq       <= 1'b0;
    end else begin
      if (ctrlWr) ctrl <= regWrData[7:0];
      if (scaleWr) scale <= {next_num, next_den};
      if (ioDirWr) ioDir <= regWrData[7:0];
      if (mskWr) irqMask <= regWrData[AXES:0];
      ioOut     <= next_io;
      irqStat   <= next_st;
      trigPulse <= trigSrc;
      irq       <= |(next_st & (mskWr ? regWrData[AXES:0] : irqMask));
    end
  end

  // Pin side: input synchroniser, outputs from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ioSync1   <= '0;
      ioSync2   <= '0;
      ioPinOut  <= '0;
      ioPinOe_n <= 8'hff;
    end else begin
      ioSync1   <= ioPinIn;
      ioSync2   <= ioSync1;
      ioPinOut  <= next_io;
      ioPinOe_n <= ~(ioDirWr ? regWrData[7:0] : ioDir);
    end
  end

  // Read mux: outputs show driven level, inputs show pin level
  wire [7:0] ioRead = (ioOut & ioDir) | (ioSync2 & ~ioDir);
  wire [1:0] rdAxis = regAddr[3:2];
  wire [2:0] rdGrp  = regAddr[7:5];
  logic [31:0] next_rd;
  always_comb begin
    next_rd = '0;
    unique case (regAddr)
      `APBU_REG_CTRL:     next_rd = {24'h0, ctrl};
      `APBU_REG_STATUS:   next_rd = {28'h0, armState[3] == apbu_pkg::APBU_ARMED,
                                     armState[2] == apbu_pkg::APBU_ARMED,
                                     armState[1] == apbu_pkg::APBU_ARMED,
                                     armState[0] == apbu_pkg::APBU_ARMED};
      `APBU_REG_IRQ_STAT: next_rd = {27'h0, irqStat};
      `APBU_REG_IRQ_MASK: next_rd = {27'h0, irqMask};
      `APBU_REG_IO_OUT:   next_rd = {24'h0, ioRead};
      `APBU_REG_IO_DIR:   next_rd = {24'h0, ioDir};
      `APBU_REG_SCALE:    next_rd = scale;
      default: begin
        if (regAddr[4] == 1'b0 && regAddr[1:0] == 2'b00) begin
          unique case (rdGrp)
            3'h1:    next_rd = brkHold[rdAxis];
            3'h2:    next_rd = refOfs[rdAxis];
            3'h3:    next_rd = armVal[rdAxis];
            3'h4:    next_rd = absPos[rdAxis];
            default: next_rd = '0;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData <= '0;
    end else if (regRd) begin
      regRdData <= next_rd;
    end else begin
      regRdData <= '0;
    end
  end

endmodule

// File: tb/apbu_core_properties.sv
/* Port checker for apbu_core, bound after the module.
   Assumes the host keeps strobes one cycle long and never both at once. */
`timescale 1ns/100ps
`include "apbu_defs.svh"
module apbu_core_properties #(
  parameter int AXES = 4
) (
  // Clock, reset and register port
  input wire logic            clk,
  input wire logic            rst,
  input wire logic [7:0]      regAddr,
  input wire logic [31:0]     regWrData,
  input wire logic            regWr,
  input wire logic            regRd,
  input wire logic [31:0]     regRdData,
  // Pins, triggers and interrupt
  input wire logic [7:0]      ioPinOut,
  input wire logic [7:0]      ioPinOe_n,
  input wire logic [AXES-1:0] trigPulse,
  input wire logic            irq
);
  // Mode shadows, since the ports alone do not show them
  logic [7:0] ctrlSh;
  logic [4:0] maskSh;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlSh <= `APBU_CTRL_RST;
      maskSh <= 5'h0;
    end else if (regWr && regAddr == `APBU_REG_CTRL) begin
      ctrlSh <= regWrData[7:0] & 8'hf7;
    end else if (regWr && regAddr == `APBU_REG_IRQ_MASK) begin
      maskSh <= regWrData[4:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_quiet; !regWr ##1 !regWr; endsequence
  sequence s_dir; regWr && regAddr == `APBU_REG_IO_DIR ##1 s_quiet; endsequence
  sequence s_mask;
    regWr && regAddr == `APBU_REG_IRQ_MASK && regWrData[4:0] == 5'h00 ##1 s_quiet;
  endsequence
  property p_rd_zero; !$past(regRd) |-> regRdData == 32'h0; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");
  property p_rd_ctrl;
    regRd && regAddr == `APBU_REG_CTRL |=> (regRdData[7:0] & 8'hf7) == $past(ctrlSh);
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");
  property p_dir; s_dir |-> ioPinOe_n == ~$past(regWrData[7:0], 2); endproperty
  a_dir: assert property (p_dir) else $error("pin enables differ");
  property p_mask; s_mask |-> !irq; endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt high");
  property p_err;
    regWr && !ctrlSh[1] && maskSh[4] && regAddr inside {[8'h20:8'h2c], [8'h40:8'h4c]}
      |-> ##[1:3] irq;
  endproperty
  a_err: assert property (p_err) else $error("no error interrupt");
  property p_link; (trigPulse & ~ctrlSh[7:4]) == 4'h0; endproperty
  a_link: assert property (p_link) else $error("trigger without link");
  property p_once(int b);
    $changed(ioPinOut[b]) |=> $stable(ioPinOut[b]) || $past(regWr) || $past(regWr, 2);
  endproperty
  for (genvar b = 0; b < 8; b++) begin : g_bit
    a_once: assert property (p_once(b)) else $error("second toggle");
  end
  property p_rst;
    $fell(rst) |-> ioPinOe_n == 8'hff && ioPinOut == 8'h0 && !irq && trigPulse == 4'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset levels wrong");
endmodule
bind apbu_core apbu_core_properties #(.AXES(AXES)) u_props (
  .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .regRd(regRd), .regRdData(regRdData), .ioPinOut(ioPinOut), .ioPinOe_n(ioPinOe_n),
  .trigPulse(trigPulse), .irq(irq));

// File: tb/apbu_motion_model.sv
/* Motion source and pin load facing the breakpoint unit.
   Assumes one bench position shared by all axes; pins have pull-ups. */
`timescale 1ns/100ps
module apbu_motion_model (
  // Clock and requested position
  input  wire logic         clk,
  input  wire logic [31:0]  posVal,
  // Unit side
  output logic      [127:0] motionPos,
  input  wire logic [7:0]   ioPinOut,
  input  wire logic [7:0]   ioPinOe_n,
  output logic      [7:0]   ioPinIn
);
  initial motionPos = 128'h0;
  always @(posedge clk) motionPos <= {4{posVal}};
  // Released pins rise to the pull-up, never hold the last value
  assign ioPinIn = ioPinOut | ioPinOe_n;
endmodule

// File: tb/test_axis_position_breakpoint_unit.sv
/* Register-level bench for the breakpoint unit.
   Assumes the checker binds itself and the motion model drives positions. */
`timescale 1ns/100ps
`include "apbu_defs.svh"
module test_axis_position_breakpoint_unit;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         regWr = 1'b0;
  logic         regRd = 1'b0;
  logic [7:0]   regAddr = 8'h0;
  logic [31:0]  regWrData = 32'h0;
  logic [31:0]  posVal = 32'h0;
  logic [3:0]   anticipHit = 4'h0;
  logic [31:0]  regRdData;
  logic [127:0] motionPos;
  logic [7:0]   ioPinIn, ioPinOut, ioPinOe_n;
  logic [3:0]   trigPulse;
  logic         irq;
  int           error_cnt = 0;
  int           samples_checked = 0;
  int           trigCnt = 0;
  apbu_core DUT (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .motionPos(motionPos),
    .anticipHit(anticipHit), .ioPinIn(ioPinIn), .ioPinOut(ioPinOut),
    .ioPinOe_n(ioPinOe_n), .trigPulse(trigPulse), .irq(irq));
  apbu_motion_model u_motion (.clk(clk), .posVal(posVal), .motionPos(motionPos),
    .ioPinOut(ioPinOut), .ioPinOe_n(ioPinOe_n), .ioPinIn(ioPinIn));
  always #2.5 clk = ~clk;
  always @(posedge clk) trigCnt <= trigCnt + int'(trigPulse[0]);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= w;
    regRd <= !w;
    @(posedge clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    check(regRdData, exp);
  endtask
  // Match and toggle latency is fixed, so a fixed settle time suffices
  task automatic mv(input logic [31:0] p);
    @(posedge clk);
    posVal <= p;
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic complete_run();
    $display("%0d checks, %0d mismatches", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #20us;
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(`APBU_REG_CTRL, 32'h3);
    rd(`APBU_REG_SCALE, `APBU_SCALE_RST);
    rd(`APBU_REG_OFS_BASE, 32'h0);
    wr(`APBU_REG_BRK_BASE + 8'hc, 32'hc000_0000);
    rd(`APBU_REG_BRK_BASE + 8'hc, 32'hc000_0000);
    rd(8'hfc, 32'h0);
    $display("reset test done");
    wr(`APBU_REG_IO_DIR, 32'hf0);
    rd(`APBU_REG_IO_DIR, 32'hf0);
    mv(32'd149);
    wr(`APBU_REG_OFS_BASE, 32'd100);
    wr(`APBU_REG_BRK_BASE, 32'd50);
    rd(`APBU_REG_ARMV_BASE, 32'h0);
    wr(`APBU_REG_CMD, 32'h1);
    rd(`APBU_REG_ARMV_BASE, 32'd150);
    rd(`APBU_REG_STATUS, 32'h1);
    mv(32'd150);
    check(ioPinOut, 32'h10);
    rd(`APBU_REG_IO_OUT, 32'h1f);
    rd(`APBU_REG_ABSP_BASE, 32'd50);
    rd(`APBU_REG_STATUS, 32'h0);
    mv(32'd149);
    mv(32'd150);
    check(ioPinOut, 32'h10);
    wr(`APBU_REG_CMD, 32'h1);
    mv(32'd150);
    check(ioPinOut, 32'h0);
    $display("absolute test done");
    mv(32'd1000);
    wr(`APBU_REG_CMD, 32'h101);
    rd(`APBU_REG_ARMV_BASE, 32'd1050);
    mv(32'd1050);
    check(ioPinOut, 32'h10);
    wr(`APBU_REG_OFS_BASE + 8'h4, 32'd7);
    rd(`APBU_REG_ABSP_BASE + 8'h4, 32'd1043);
    rd(`APBU_REG_OFS_BASE, 32'd100);
    $display("relative test done");
    wr(`APBU_REG_IO_DIR, 32'hff);
    wr(`APBU_REG_IRQ_STAT, 32'h1f);
    rd(`APBU_REG_IRQ_STAT, 32'h0);
    check(irq, 32'h0);
    wr(`APBU_REG_CTRL, 32'h16);
    wr(`APBU_REG_IRQ_MASK, 32'h11);
    wr(`APBU_REG_CMD, 32'h1);
    mv(32'd150);
    check(ioPinOut, 32'h11);
    check(trigCnt, 32'h1);
    check(irq, 32'h1);
    wr(`APBU_REG_OFS_BASE, 32'd5);
    @(posedge clk);
    anticipHit <= 4'h1;
    @(posedge clk);
    anticipHit <= 4'h0;
    mv(32'd150);
    check(trigCnt, 32'h2);
    $display("stepper link test done");
    wr(`APBU_REG_CTRL, 32'h12);
    wr(`APBU_REG_CMD, 32'h1);
    mv(32'd55);
    check(ioPinOut, 32'h11);
    wr(`APBU_REG_CMD, 32'h2);
    wr(`APBU_REG_OFS_BASE + 8'h8, 32'd3);
    rd(`APBU_REG_OFS_BASE + 8'h8, 32'd3);
    wr(`APBU_REG_IRQ_STAT, 32'h1f);
    wr(`APBU_REG_CTRL, 32'h0);
    wr(`APBU_REG_BRK_BASE, 32'd9);
    rd(`APBU_REG_IRQ_STAT, 32'h10);
    rd(`APBU_REG_BRK_BASE, 32'd50);
    wr(`APBU_REG_IRQ_STAT, 32'h1f);
    wr(`APBU_REG_OFS_BASE, 32'd9);
    rd(`APBU_REG_IRQ_STAT, 32'h10);
    wr(`APBU_REG_IRQ_MASK, 32'h1f);
    rd(`APBU_REG_OFS_BASE, 32'd5);
    check(irq, 32'h1);
    wr(`APBU_REG_IRQ_MASK, 32'h0);
    rd(`APBU_REG_IRQ_MASK, 32'h0);
    check(irq, 32'h0);
    $display("loop mode test done");
    wr(`APBU_REG_CTRL, 32'h3);
    wr(`APBU_REG_SCALE, 32'h0002_0001);
    wr(`APBU_REG_CMD, 32'h1);
    rd(`APBU_REG_ARMV_BASE, 32'd30);
    wr(`APBU_REG_SCALE, 32'h0000_0003);
    rd(`APBU_REG_SCALE, 32'h0002_0003);
    $display("scale test done");
    complete_run();
  end
endmodule
